/* tfd_consts.svh */
// Offsets, selects and FIFO depth constants of the task file decoder
`ifndef TFD_CONSTS_SVH
`define TFD_CONSTS_SVH

`define TFD_IDX_MEMORY      2'h0
`define TFD_IDX_CONTIG      2'h1
`define TFD_IDX_PRIMARY     2'h2
`define TFD_IDX_SECONDARY   2'h3

`define TFD_OFS_DATA        4'h0
`define TFD_OFS_ERR_FEAT    4'h1
`define TFD_OFS_SEC_COUNT   4'h2
`define TFD_OFS_SEC_NUMBER  4'h3
`define TFD_OFS_CYL_LOW     4'h4
`define TFD_OFS_CYL_HIGH    4'h5
`define TFD_OFS_DRV_HEAD    4'h6
`define TFD_OFS_STAT_CMD    4'h7
`define TFD_OFS_EVEN_DATA   4'h8
`define TFD_OFS_ODD_DATA    4'h9
`define TFD_OFS_DUP_ERR     4'hd
`define TFD_OFS_ALT_CTRL    4'he
`define TFD_OFS_DRV_ADDR    4'hf

`define TFD_PRI_BLOCK       6'h1f
`define TFD_PRI_ALT_BLOCK   6'h3f
`define TFD_SEC_BLOCK       6'h17
`define TFD_SEC_ALT_BLOCK   6'h37
`define TFD_ALT_LOW_STAT    4'h6
`define TFD_ALT_LOW_ADDR    4'h7

`define TFD_FIFO_DEPTH      32

`endif

/* tfd_pkg.sv */
// Types shared by the task file decoder
package tfd_pkg;

    typedef enum logic [3:0] {
        TFD_REG_NONE  = 4'h0,
        TFD_REG_DATA  = 4'h1,
        TFD_REG_ERR   = 4'h2,
        TFD_REG_FEAT  = 4'h3,
        TFD_REG_SCNT  = 4'h4,
        TFD_REG_SNUM  = 4'h5,
        TFD_REG_CYLL  = 4'h6,
        TFD_REG_CYLH  = 4'h7,
        TFD_REG_DRVH  = 4'h8,
        TFD_REG_STAT  = 4'h9,
        TFD_REG_CMD   = 4'ha,
        TFD_REG_ASTAT = 4'hb,
        TFD_REG_DCTL  = 4'hc,
        TFD_REG_DADDR = 4'hd
    } tfd_reg_e;

    typedef struct packed {
        logic       reg_sel_b;
        logic [10:0] addr;
        logic       oe_b;
        logic       we_b;
        logic       iord_b;
        logic       iowr_b;
        logic [15:0] wdata;
    } tfd_host_s;

    typedef struct packed {
        tfd_reg_e   target;
        logic       is_write;
        logic       byte_odd;
        logic       byte_mode;
        logic [15:0] wdata;
    } tfd_access_s;

endpackage

/* tfd_fifo.sv */
// Sector data FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none

module tfd_fifo
    import tfd_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
        $error("tfd_fifo: depth must be a power of two, at least 2");
    end

    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } tfd_fifo_state_s;

    tfd_fifo_state_s  st_reg;
    tfd_fifo_state_s  st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = (st_reg.wr_ptr - st_reg.rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = st_reg.wr_ptr != st_reg.rd_ptr;
    assign push      = in_valid && in_ready && clk_en;
    assign pop       = out_valid && out_ready && clk_en;
    assign out_data  = mem[st_reg.rd_ptr[AW-1:0]];

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[st_reg.wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule
`default_nettype wire

/* tfd_decoder.sv */
// Task file address decoder with register steering and sector data FIFO
// ****************************************************************
// Overview of operation
// R1: The configuration index field picks one of four host address decode maps.
// R2: Index 0 decodes memory cycles with register select high and A10 low, A3..A0 as offset.
// R3: Index 0 with A10 high ignores A9..A1 and A0 picks the even or odd data byte.
// R4: Index 1 decodes I/O cycles with register select low using A3..A0 as offset.
// R5: Index 2 uses block 1FH for the first eight registers and 3FH with 6 or 7 for the rest.
// R6: Index 3 decodes like index 2 with blocks 17H and 37H.
// R7: Memory and contiguous maps alias offset 9H to odd data and DH to error or feature.
// R8: Shared offsets steer reads and writes apart, and the drive address is read only.
// R9: The data register is a 16-bit port taking word or byte host accesses.
// R10: Offsets AH, BH and CH select nothing; writes drop and reads give no defined value.
// ****************************************************************
`timescale 1ns/100ps
`default_nettype none
`include "tfd_consts.svh"

module tfd_decoder
    import tfd_pkg::*;
#(
    parameter int FIFO_DEPTH = `TFD_FIFO_DEPTH
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic [1:0]  config_index,
    input  wire logic        reg_sel_b_pin,
    input  wire logic [10:0] addr_pin,
    input  wire logic        oe_b_pin,
    input  wire logic        we_b_pin,
    input  wire logic        iord_b_pin,
    input  wire logic        iowr_b_pin,
    input  wire logic        wide_b_pin,
    input  wire logic [15:0] data_in_pin,
    output logic      [15:0] data_out_pin,
    output logic             data_oe,
    output logic             acc_valid,
    output tfd_access_s      acc,
    input  wire logic [7:0]  reg_rdata,
    output logic             wr_data_valid,
    input  wire logic        wr_data_ready,
    output logic      [15:0] wr_data,
    input  wire logic        rd_data_valid,
    output logic             rd_data_ready,
    input  wire logic [15:0] rd_data
);

    if (FIFO_DEPTH < 2) begin
        $error("tfd_decoder: fifo depth too small");
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    typedef struct packed {
        tfd_host_s   meta;
        tfd_host_s   sync;
        logic [1:0]  wide_sync;
        logic        strobe_d;
        logic [15:0] rdata;
        logic        oe;
        logic        acc_valid;
        tfd_access_s acc;
    } tfd_state_s;

    tfd_state_s  st_reg;
    tfd_state_s  st_next;
    tfd_host_s   pins;
    tfd_host_s   h;
    logic        mem_cyc;
    logic        io_cyc;
    logic        rd_strobe;
    logic        wr_strobe;
    logic        strobe;
    logic        selected;
    logic [3:0]  ofs;
    logic        byte_mode;
    tfd_reg_e    target;
    logic        data_hit;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic        rd_pop;

    assign pins = '{reg_sel_b: reg_sel_b_pin, addr: addr_pin, oe_b: oe_b_pin,
                    we_b: we_b_pin, iord_b: iord_b_pin, iowr_b: iowr_b_pin,
                    wdata: data_in_pin};
    assign h    = st_reg.sync;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    assign mem_cyc   = h.reg_sel_b && (!h.oe_b || !h.we_b);
    assign io_cyc    = !h.reg_sel_b && (!h.iord_b || !h.iowr_b);
    assign byte_mode = st_reg.wide_sync[1];

    always_comb begin
        selected  = 1'b0;
        ofs       = h.addr[3:0];
        rd_strobe = 1'b0;
        wr_strobe = 1'b0;
        unique case (config_index)   // [R1]
            `TFD_IDX_MEMORY: begin
                rd_strobe = !h.oe_b;   // [R2]
                wr_strobe = !h.we_b;
                if (mem_cyc) begin
                    selected = 1'b1;
                    if (h.addr[10]) begin
                        ofs = h.addr[0] ? `TFD_OFS_ODD_DATA : `TFD_OFS_EVEN_DATA;   // [R3]
                    end
                end
            end
            `TFD_IDX_CONTIG: begin
                rd_strobe = !h.iord_b;   // [R4]
                wr_strobe = !h.iowr_b;
                selected  = io_cyc;
            end
            `TFD_IDX_PRIMARY, `TFD_IDX_SECONDARY: begin
                rd_strobe = !h.iord_b;
                wr_strobe = !h.iowr_b;
                if (io_cyc) begin
                    if (h.addr[9:4] == ((config_index == `TFD_IDX_PRIMARY) ?
                            `TFD_PRI_BLOCK : `TFD_SEC_BLOCK) && !h.addr[3]) begin   // [R5] [R6]
                        selected = 1'b1;
                    end else if (h.addr[9:4] == ((config_index == `TFD_IDX_PRIMARY) ?
                            `TFD_PRI_ALT_BLOCK : `TFD_SEC_ALT_BLOCK) &&
                            (h.addr[3:0] == `TFD_ALT_LOW_STAT ||
                             h.addr[3:0] == `TFD_ALT_LOW_ADDR)) begin   // [R5] [R6]
                        selected = 1'b1;
                        ofs      = h.addr[3:0] | 4'h8;
                    end
                end
            end
        endcase
    end

    assign strobe = selected && (rd_strobe || wr_strobe);

    // Register steering by offset and direction
    always_comb begin
        target = TFD_REG_NONE;
        unique case (ofs)
            `TFD_OFS_DATA, `TFD_OFS_EVEN_DATA, `TFD_OFS_ODD_DATA: target = TFD_REG_DATA;   // [R7] [R9]
            `TFD_OFS_ERR_FEAT, `TFD_OFS_DUP_ERR: target = wr_strobe ? TFD_REG_FEAT : TFD_REG_ERR;   // [R7] [R8]
            `TFD_OFS_SEC_COUNT:  target = TFD_REG_SCNT;
            `TFD_OFS_SEC_NUMBER: target = TFD_REG_SNUM;
            `TFD_OFS_CYL_LOW:    target = TFD_REG_CYLL;
            `TFD_OFS_CYL_HIGH:   target = TFD_REG_CYLH;
            `TFD_OFS_DRV_HEAD:   target = TFD_REG_DRVH;
            `TFD_OFS_STAT_CMD:   target = wr_strobe ? TFD_REG_CMD : TFD_REG_STAT;   // [R8]
            `TFD_OFS_ALT_CTRL:   target = wr_strobe ? TFD_REG_DCTL : TFD_REG_ASTAT;   // [R8]
            `TFD_OFS_DRV_ADDR:   target = wr_strobe ? TFD_REG_NONE : TFD_REG_DADDR;   // [R8]
            default:             target = TFD_REG_NONE;   // [R10]
        endcase
        if (!selected) begin
            target = TFD_REG_NONE;
        end
    end

    // ****************************************************************
    // Data path FIFO
    // ****************************************************************
    assign data_hit      = strobe && (target == TFD_REG_DATA);
    assign fifo_in_valid = data_hit && wr_strobe && !st_reg.strobe_d;   // [R9]
    assign rd_pop        = data_hit && rd_strobe && !st_reg.strobe_d && clk_en;
    assign rd_data_ready = rd_pop;

    tfd_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_wr_fifo (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (byte_mode ? {8'h00, h.wdata[7:0]} : h.wdata),
        .out_valid (fifo_out_valid),
        .out_ready (wr_data_ready),
        .out_data  (fifo_out_data)
    );

    assign wr_data_valid = fifo_out_valid;
    assign wr_data       = fifo_out_data;

    // ****************************************************************
    // State update
    // ****************************************************************
    always_comb begin
        st_next           = st_reg;
        st_next.meta      = pins;
        st_next.sync      = st_reg.meta;
        st_next.wide_sync = {st_reg.wide_sync[0], wide_b_pin};
        st_next.strobe_d  = strobe;
        st_next.acc_valid = 1'b0;
        st_next.oe        = strobe && rd_strobe;
        if (strobe && !st_reg.strobe_d && !(data_hit && wr_strobe && !fifo_in_ready)) begin
            st_next.acc_valid      = (target != TFD_REG_NONE);   // [R10]
            st_next.acc.target     = target;
            st_next.acc.is_write   = wr_strobe;
            st_next.acc.byte_odd   = (ofs == `TFD_OFS_ODD_DATA);
            st_next.acc.byte_mode  = byte_mode || ofs[3];
            st_next.acc.wdata      = h.wdata;
        end
        if (rd_pop && rd_data_valid) begin
            st_next.rdata = (ofs == `TFD_OFS_ODD_DATA) ? {8'h00, rd_data[15:8]} :
                            ((byte_mode || ofs[3]) ? {8'h00, rd_data[7:0]} : rd_data);
        end else if (strobe && rd_strobe && target != TFD_REG_DATA) begin
            st_next.rdata = {8'h00, reg_rdata};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg           <= '0;
            st_reg.meta      <= '{reg_sel_b: 1'b1, addr: 11'h000, oe_b: 1'b1, we_b: 1'b1,
                                  iord_b: 1'b1, iowr_b: 1'b1, wdata: 16'h0000};
            st_reg.sync      <= '{reg_sel_b: 1'b1, addr: 11'h000, oe_b: 1'b1, we_b: 1'b1,
                                  iord_b: 1'b1, iowr_b: 1'b1, wdata: 16'h0000};
            st_reg.wide_sync <= 2'h3;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign data_out_pin = st_reg.rdata;
    assign data_oe      = st_reg.oe;
    assign acc_valid    = st_reg.acc_valid;
    assign acc          = st_reg.acc;

endmodule
`default_nettype wire

/* tfd_decoder_asserts.sv */
// Port checker of the task file decoder and its bind
`timescale 1ns/100ps
`default_nettype none
module tfd_decoder_asserts
    import tfd_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic [1:0]  config_index,
    input wire logic        reg_sel_b_pin,
    input wire logic [10:0] addr_pin,
    input wire logic        we_b_pin,
    input wire logic        iowr_b_pin,
    input wire logic        acc_valid,
    input wire tfd_access_s acc,
    input wire logic        wr_data_valid,
    input wire logic        data_oe,
    input wire logic        rd_data_ready
);
    // ********
    // Decode and data path checks
    // ********
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_hit(logic [1:0] i);
        acc_valid && config_index == i;
    endsequence
    sequence s_data_wr;
        acc_valid && acc.is_write && acc.target == TFD_REG_DATA;
    endsequence
    AST_MEM_SEL: assert property (s_hit(2'h0) |-> $past(reg_sel_b_pin, 2))
        else $error("memory map took select low");
    AST_MEM_WIN: assert property (s_hit(2'h0) ##0 $past(addr_pin[10], 2) |->
        acc.target == TFD_REG_DATA && acc.byte_odd == $past(addr_pin[0], 2))
        else $error("data window wrong");
    AST_IO_SEL: assert property (s_hit(2'h1) |-> !$past(reg_sel_b_pin, 2))
        else $error("io map took select high");
    AST_PRI_BLK: assert property (s_hit(2'h2) |->
        $past(addr_pin[9:4], 2) inside {6'h1f, 6'h3f})
        else $error("primary block wrong");
    AST_SEC_BLK: assert property (s_hit(2'h3) |->
        $past(addr_pin[9:4], 2) inside {6'h17, 6'h37})
        else $error("secondary block wrong");
    AST_DUP_ERR: assert property (acc_valid && !config_index[1] &&
        $past(addr_pin[3:0], 2) == 4'hd &&
        !(config_index == 2'h0 && $past(addr_pin[10], 2)) |->
        acc.target == (acc.is_write ? TFD_REG_FEAT : TFD_REG_ERR))
        else $error("dup error alias wrong");
    AST_DIR: assert property (acc_valid |->
        acc.is_write == $past(!iowr_b_pin || !we_b_pin, 2))
        else $error("direction wrong");
    AST_STEER: assert property (acc_valid |->
        !(acc.is_write && acc.target inside {TFD_REG_ERR, TFD_REG_STAT,
        TFD_REG_ASTAT, TFD_REG_DADDR}))
        else $error("read register on write");
    AST_NO_NONE: assert property (acc_valid |-> acc.target != TFD_REG_NONE)
        else $error("pulse without target");
    AST_PUSH: assert property (s_data_wr |-> wr_data_valid)
        else $error("data write not queued");
    AST_OE: assert property (acc_valid |-> data_oe == !acc.is_write)
        else $error("data drive wrong");
    AST_POP: assert property (rd_data_ready |=> acc_valid && !acc.is_write &&
        acc.target == TFD_REG_DATA)
        else $error("read pop without data read");
endmodule
bind tfd_decoder tfd_decoder_asserts u_chk (.sys_clk, .rst_b, .config_index,
    .reg_sel_b_pin, .addr_pin, .we_b_pin, .iowr_b_pin, .acc_valid, .acc, .wr_data_valid,
    .data_oe, .rd_data_ready);
`default_nettype wire

/* tfd_host_model.sv */
// Host bus controller model driving memory and I/O cycles
`timescale 1ns/100ps
`default_nettype none
module tfd_host_model (
    input  wire logic   sys_clk,
    input  wire logic   acc_valid,
    output logic        reg_sel_b_pin,
    output logic [10:0] addr_pin,
    output logic        oe_b_pin,
    output logic        we_b_pin,
    output logic        iord_b_pin,
    output logic        iowr_b_pin,
    output logic        wide_b_pin,
    output logic [15:0] data_in_pin
);
    // ********
    // Bus cycle
    // ********
    initial begin
        {reg_sel_b_pin, oe_b_pin, we_b_pin, iord_b_pin, iowr_b_pin, wide_b_pin} = 6'h3f;
        addr_pin = 11'h000;
        data_in_pin = 16'h0000;
    end
    // Strobe held until answer or eight cycles, then four idle cycles
    task automatic cyc(input logic io, wr, rs, wb, input logic [10:0] a,
                       input logic [15:0] d, output logic hit);
        hit = 1'b0;
        @(posedge sys_clk);
        #1;
        reg_sel_b_pin = rs;
        addr_pin = a;
        wide_b_pin = wb;
        data_in_pin = d;
        {iord_b_pin, iowr_b_pin, oe_b_pin, we_b_pin} = ~{io & !wr, io & wr, !io & !wr, !io & wr};
        for (int n = 0; n < 8 && !hit; n++) begin
            @(negedge sys_clk);
            hit = (acc_valid === 1'b1);
        end
        @(posedge sys_clk);
        #1;
        {iord_b_pin, iowr_b_pin, oe_b_pin, we_b_pin} = 4'hf;
        data_in_pin = ~d;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

/* tfd_decoder_tb.sv */
// Self-checking testbench of the task file decoder
`timescale 1ns/100ps
`default_nettype none
module tfd_decoder_tb import tfd_pkg::*; ;
    logic        sys_clk, rst_b, reg_sel_b_pin, oe_b_pin, we_b_pin, iord_b_pin, iowr_b_pin;
    logic        wide_b_pin, data_oe, acc_valid, wr_data_valid, rd_data_ready, hit;
    logic        wr_data_ready = 1'b1;
    logic        wb = 1'b0;
    logic        en = 1'b1;
    logic [1:0]  cfg = 2'h0;
    logic [10:0] addr_pin;
    logic [15:0] data_in_pin, data_out_pin, wr_data;
    logic [15:0] wd = 16'h00a5;
    logic [3:0]  sh [5] = '{4'h1, 4'h7, 4'hd, 4'he, 4'hf};
    tfd_access_s acc;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cyc_cnt = 0;
    // ********
    // Harness
    // ********
    tfd_decoder dut (.sys_clk, .rst_b, .clk_en(en), .config_index(cfg), .reg_sel_b_pin,
        .addr_pin, .oe_b_pin, .we_b_pin, .iord_b_pin, .iowr_b_pin, .wide_b_pin, .data_in_pin,
        .data_out_pin, .data_oe, .acc_valid, .acc, .reg_rdata(8'h5a), .wr_data_valid,
        .wr_data_ready, .wr_data, .rd_data_valid(1'b1), .rd_data_ready, .rd_data(16'hbeef));
    tfd_host_model host (.sys_clk, .acc_valid, .reg_sel_b_pin, .addr_pin, .oe_b_pin,
        .we_b_pin, .iord_b_pin, .iowr_b_pin, .wide_b_pin, .data_in_pin);
    function automatic tfd_reg_e exp_tgt(input logic [3:0] o, input logic wr);
        case (o)
            4'h0, 4'h8, 4'h9: return TFD_REG_DATA;
            4'h1, 4'hd: return wr ? TFD_REG_FEAT : TFD_REG_ERR;
            4'h2: return TFD_REG_SCNT;
            4'h3: return TFD_REG_SNUM;
            4'h4: return TFD_REG_CYLL;
            4'h5: return TFD_REG_CYLH;
            4'h6: return TFD_REG_DRVH;
            4'h7: return wr ? TFD_REG_CMD : TFD_REG_STAT;
            4'he: return wr ? TFD_REG_DCTL : TFD_REG_ASTAT;
            4'hf: return wr ? TFD_REG_NONE : TFD_REG_DADDR;
            default: return TFD_REG_NONE;
        endcase
    endfunction
    task automatic cmp(input string nm, input logic [15:0] e, s);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic go(input logic io, wr, rs, input logic [10:0] a, input tfd_reg_e e);
        host.cyc(io, wr, rs, wb, a, wd, hit);
        cmp("hit", 16'(e != TFD_REG_NONE), 16'(hit));
        if (hit) begin
            cmp("target", 16'(e), 16'(acc.target));
            cmp("write", 16'(wr), 16'(acc.is_write));
        end
    endtask
    task automatic close_out();
        if (num_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_mem();
        #1 cfg = 2'h0;
        for (int o = 0; o < 16; o++)
            go(0, 0, 1, {7'h2a, 4'(o)}, exp_tgt(4'(o), 0));
        foreach (sh[i])
            go(0, 1, 1, {7'h15, sh[i]}, exp_tgt(sh[i], 1));
        go(0, 0, 1, 11'h402, TFD_REG_DATA);
        cmp("odd", 16'h0, 16'(acc.byte_odd));
        go(0, 1, 1, 11'h7f9, TFD_REG_DATA);
        cmp("odd", 16'h1, 16'(acc.byte_odd));
        go(0, 0, 0, 11'h002, TFD_REG_NONE);
        go(1, 0, 1, 11'h002, TFD_REG_NONE);
    endtask
    task automatic t_io();
        #1 cfg = 2'h1;
        for (int o = 0; o < 16; o++)
            go(1, 0, 0, {7'h55, 4'(o)}, exp_tgt(4'(o), 0));
        foreach (sh[i])
            go(1, 1, 0, {7'h6a, sh[i]}, exp_tgt(sh[i], 1));
        go(1, 0, 1, 11'h003, TFD_REG_NONE);
        go(0, 0, 0, 11'h003, TFD_REG_NONE);
    endtask
    task automatic t_fixed();
        logic [5:0] b, ab;
        for (int k = 0; k < 2; k++) begin
            #1 cfg = 2'h2 + 2'(k);
            b = k ? 6'h17 : 6'h1f;
            ab = k ? 6'h37 : 6'h3f;
            for (int o = 0; o < 8; o++)
                go(1, 0, 0, {1'b1, b, 4'(o)}, exp_tgt(4'(o), 0));
            go(1, 0, 0, {1'b0, ab, 4'h6}, TFD_REG_ASTAT);
            go(1, 0, 0, {1'b0, ab, 4'h7}, TFD_REG_DADDR);
            go(1, 1, 0, {1'b0, ab, 4'h6}, TFD_REG_DCTL);
            go(1, 1, 0, {1'b0, ab, 4'h7}, TFD_REG_NONE);
            go(1, 0, 0, {1'b0, b, 4'h9}, TFD_REG_NONE);
            go(1, 0, 0, {1'b0, ab, 4'h5}, TFD_REG_NONE);
            go(1, 0, 0, {1'b0, b ^ 6'h08, 4'h1}, TFD_REG_NONE);
        end
    endtask
    task automatic t_data();
        int n;
        #1 cfg = 2'h1;
        wr_data_ready = 1'b0;
        for (int i = 0; i < 33; i++) begin
            wd = 16'h0100 + 16'(i);
            go(1, 1, 0, 11'h000, i < 32 ? TFD_REG_DATA : TFD_REG_NONE);
        end
        #1 cmp("fifo head", 16'h0100, wr_data);
        wr_data_ready = 1'b1;
        n = 0;
        repeat (40) begin
            @(negedge sys_clk);
            n += int'(wr_data_valid === 1'b1);
        end
        cmp("drained", 16'd32, 16'(n));
        go(1, 0, 0, 11'h000, TFD_REG_DATA);
        cmp("word", 16'hbeef, data_out_pin);
        cmp("word mode", 16'h0, 16'(acc.byte_mode));
        wb = 1'b1;
        go(1, 0, 0, 11'h009, TFD_REG_DATA);
        cmp("odd byte", 16'h00be, {8'h0, data_out_pin[7:0]});
        cmp("byte mode", 16'h1, 16'(acc.byte_mode));
        #1 en = 1'b0;
        go(1, 1, 0, 11'h002, TFD_REG_NONE);
        #1 en = 1'b1;
        go(1, 0, 0, 11'h002, TFD_REG_SCNT);
        cmp("reg read", 16'h005a, {8'h0, data_out_pin[7:0]});
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 6000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        rst_b = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1 rst_b = 1'b1;
        t_mem();
        t_io();
        t_fixed();
        t_data();
        close_out();
    end
endmodule
`default_nettype wire
